// [verilog/pwc_consts.vh]
`ifndef PWC_CONSTS_VH
`define PWC_CONSTS_VH
// ==========================================
// register byte addresses
`define PWC_ADDR_CNT_LO    16'hf914
`define PWC_ADDR_CNT_HI    16'hf915
`define PWC_ADDR_CON0      16'hf916
`define PWC_ADDR_CON1      16'hf917
`define PWC_ADDR_CON2      16'hf918
// ==========================================
// reset values
`define PWC_RST_CON0       8'h00
`define PWC_RST_CON1       8'h40
`define PWC_RST_CON2       8'h00
// ==========================================
// clock and interrupt control fields
`define PWC_CS_LO          0
`define PWC_CS_HI          1
`define PWC_IP_LO          2
`define PWC_IP_HI          3
`define PWC_POL_BIT        4
`define PWC_FSTOP_BIT      5
// ==========================================
// run and status fields
`define PWC_RUN_BIT        0
`define PWC_TGEN_BIT       1
`define PWC_ESF_BIT        5
`define PWC_FLG_BIT        6
`define PWC_ACT_BIT        7
// ==========================================
// trigger mode fields
`define PWC_MODE_LO        0
`define PWC_MODE_HI        1
`define PWC_EXCL_BIT       2
`define PWC_EDGE_LO        4
`define PWC_EDGE_HI        5
`define PWC_OST_BIT        7
// ==========================================
// field codes
`define PWC_CS_LOW         2'h0
`define PWC_CS_HTB         2'h1
`define PWC_CS_PLL         2'h2
`define PWC_IP_PERIOD      2'h0
`define PWC_IP_DUTY        2'h1
`define PWC_MODE_NONE      2'h0
`define PWC_MODE_START     2'h1
`define PWC_MODE_STOP      2'h2
`define PWC_MODE_BOTH      2'h3
`define PWC_EDGE_RR        2'h0
`define PWC_EDGE_RSTOP     2'h1
`define PWC_EDGE_RSTART    2'h2
`define PWC_EDGE_FF        2'h3
`endif

// [verilog/pwc_channel_ctrl.v]
// Summary of operation
// - count clock chosen by two-bit select, 11 none
// - interrupt on period, duty or both matches
// - output idles 1 positive, 0 negative
// - forced-stop bit halts the channel
// - run bit written by software starts/stops
// - external trigger obeyed only when enabled
// - emergency flag set by event, write-1 clears
// - output flag readable, set by counter write
// - read-only count-active status bit
// - continuous: external stop clears run bit
// - one-shot: period match also clears run
// - external mode: none, start, stop, both
// - clear counter on external stop if enabled
// - edge mode decodes start and stop edges
// - one-shot select bit picks one-shot mode
// - duty match clears flag, period match sets
// - one more clock edge after run cleared
`timescale 1ns/100ps
`default_nettype none
`include "pwc_consts.vh"

module pwc_channel_ctrl #(
   parameter ADDR_W = 16
) (
   input  wire              clk,
   input  wire              sys_rst,
   input  wire [ADDR_W-1:0] sfr_addr,
   input  wire [7:0]        sfr_wdata,
   input  wire              sfr_wr,
   input  wire              sfr_rd,
   output reg  [7:0]        sfr_rdata,
   input  wire              low_speed_clock,
   input  wire              high_timebase_clock,
   input  wire              pll_clock,
   input  wire              ext_trigger,
   input  wire              emergency_stop,
   input  wire              period_match,
   input  wire              duty_match,
   output reg               count_step,
   output reg               counter_clear,
   output reg               buffer_reload,
   output reg               pwm_irq,
   output reg               pwm_out
);

   // ==========================================
   // functions
   function falling;
      input prev;
      input cur;
      begin
         falling = prev & ~cur;
      end
   endfunction

   function sel_clk;
      input [1:0] cs;
      input       ls;
      input       htb;
      input       pll;
      begin
         case (cs)
            `PWC_CS_LOW: sel_clk = ls;
            `PWC_CS_HTB: sel_clk = htb;
            `PWC_CS_PLL: sel_clk = pll;
            default:     sel_clk = 1'b0;
         endcase
      end
   endfunction

   // ==========================================
   // control and status state
   reg  [1:0] cs_q;
   reg  [1:0] ip_q;
   reg        pol_q;
   reg        fstop_q;
   reg        run_q;
   reg        tgen_q;
   reg        esf_q;
   reg        flg_q;
   reg        act_q;
   reg  [1:0] mode_q;
   reg        excl_q;
   reg  [1:0] edge_q;
   reg        ost_q;
   reg        ck_prev_q;
   reg        trig_prev_q;

   wire       ck_cur;
   wire       tick;
   wire       trig_rise;
   wire       trig_fall;
   wire       wr0;
   wire       wr1;
   wire       wr2;
   wire       wr_cnt;

   // ==========================================
   // count clock edge detect
   // prohibited select code gives a constant level, so no ticks
   assign ck_cur = sel_clk(cs_q, low_speed_clock,
                           high_timebase_clock, pll_clock);
   assign tick   = falling(ck_prev_q, ck_cur);

   // trigger idles low, so reset gives no false edge
   assign trig_rise = ext_trigger & ~trig_prev_q;
   assign trig_fall = falling(trig_prev_q, ext_trigger);

   assign wr0    = sfr_wr & (sfr_addr == `PWC_ADDR_CON0);
   assign wr1    = sfr_wr & (sfr_addr == `PWC_ADDR_CON1);
   assign wr2    = sfr_wr & (sfr_addr == `PWC_ADDR_CON2);
   assign wr_cnt = sfr_wr & ((sfr_addr == `PWC_ADDR_CNT_LO) |
                             (sfr_addr == `PWC_ADDR_CNT_HI));

   // ==========================================
   // external start and stop decode
   reg ext_start;
   reg ext_stop;

   always @* begin
      ext_start = 1'b0;
      ext_stop  = 1'b0;
      case (mode_q)
         `PWC_MODE_NONE: begin
            ext_start = 1'b0;
         end
         // single-action modes act on the rising edge
         `PWC_MODE_START: begin
            ext_start = trig_rise;
         end
         `PWC_MODE_STOP: begin
            ext_stop = trig_rise;
         end
         `PWC_MODE_BOTH: begin
            case (edge_q)
               `PWC_EDGE_RR: begin
                  ext_start = trig_rise & ~run_q;
                  ext_stop  = trig_rise & run_q;
               end
               `PWC_EDGE_RSTOP: begin
                  ext_start = trig_fall;
                  ext_stop  = trig_rise;
               end
               `PWC_EDGE_RSTART: begin
                  ext_start = trig_rise;
                  ext_stop  = trig_fall;
               end
               `PWC_EDGE_FF: begin
                  ext_start = trig_fall & ~run_q;
                  ext_stop  = trig_fall & run_q;
               end
               default: begin
                  ext_start = 1'b0;
               end
            endcase
         end
         default: begin
            ext_start = 1'b0;
         end
      endcase
      if (!tgen_q) begin
         ext_start = 1'b0;
         ext_stop  = 1'b0;
      end
   end

   // ==========================================
   // register writes and counting sequence
   // later assignments win: hardware events override register writes, but a counter write beats the step and the flag
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_q          <= 2'h0;
         ip_q          <= 2'h0;
         pol_q         <= 1'b0;
         fstop_q       <= 1'b0;
         run_q         <= 1'b0;
         tgen_q        <= 1'b0;
         esf_q         <= 1'b0;
         flg_q         <= 1'b1;
         act_q         <= 1'b0;
         mode_q        <= 2'h0;
         excl_q        <= 1'b0;
         edge_q        <= 2'h0;
         ost_q         <= 1'b0;
         ck_prev_q     <= 1'b0;
         trig_prev_q   <= 1'b0;
         count_step    <= 1'b0;
         counter_clear <= 1'b0;
         buffer_reload <= 1'b0;
         pwm_irq       <= 1'b0;
      end else begin
         ck_prev_q     <= ck_cur;
         trig_prev_q   <= ext_trigger;
         count_step    <= 1'b0;
         counter_clear <= 1'b0;
         buffer_reload <= 1'b0;
         pwm_irq       <= 1'b0;

         // software writes; reserved bits are not stored
         if (wr0) begin
            cs_q    <= sfr_wdata[`PWC_CS_HI:`PWC_CS_LO];
            ip_q    <= sfr_wdata[`PWC_IP_HI:`PWC_IP_LO];
            pol_q   <= sfr_wdata[`PWC_POL_BIT];
            fstop_q <= sfr_wdata[`PWC_FSTOP_BIT];
         end
         if (wr1) begin
            run_q  <= sfr_wdata[`PWC_RUN_BIT];
            tgen_q <= sfr_wdata[`PWC_TGEN_BIT];
            if (sfr_wdata[`PWC_ESF_BIT])
               esf_q <= 1'b0;
         end
         if (wr2) begin
            mode_q <= sfr_wdata[`PWC_MODE_HI:`PWC_MODE_LO];
            excl_q <= sfr_wdata[`PWC_EXCL_BIT];
            edge_q <= sfr_wdata[`PWC_EDGE_HI:`PWC_EDGE_LO];
            ost_q  <= sfr_wdata[`PWC_OST_BIT];
         end

         // counter byte write restarts the count
         if (wr_cnt) begin
            counter_clear <= 1'b1;
         end

         // external trigger
         if (ext_start) begin
            run_q <= 1'b1;
         end
         if (ext_stop) begin
            run_q   <= 1'b0;
            pwm_irq <= run_q;
            if (excl_q)
               counter_clear <= 1'b1;
         end

         // work done on a falling edge of the count clock
         if (tick && !fstop_q) begin
            if (act_q) begin
               if (period_match) begin
                  flg_q         <= 1'b1;
                  counter_clear <= 1'b1;
                  buffer_reload <= 1'b1;
                  if (ip_q != `PWC_IP_DUTY)
                     pwm_irq <= 1'b1;
                  if (ost_q && !ext_start)
                     run_q <= 1'b0;
               end else begin
                  count_step <= 1'b1;
                  if (duty_match) begin
                     flg_q <= 1'b0;
                     if (ip_q != `PWC_IP_PERIOD)
                        pwm_irq <= 1'b1;
                  end
               end
               // the stopping edge still counts once
               if (!run_q)
                  act_q <= 1'b0;
            end else if (run_q) begin
               act_q <= 1'b1;
            end
         end

         // a same-cycle clear beats the step
         // the counter would otherwise leave zero at once
         if (wr_cnt || (ext_stop && excl_q)) begin
            count_step <= 1'b0;
         end

         // forced stop holds the channel idle
         if (fstop_q) begin
            act_q <= 1'b0;
         end

         // a write to the counter leaves the flag high
         if (wr_cnt) begin
            flg_q <= 1'b1;
         end

         // emergency event beats a same-cycle clear
         if (emergency_stop) begin
            esf_q <= 1'b1;
            run_q <= 1'b0;
            act_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // pwm output
   // flag is 1 after reset or a counter write, so polarity alone then sets the idle level
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwm_out <= 1'b1;
      end else if (fstop_q) begin
         pwm_out <= ~pol_q;
      end else begin
         pwm_out <= flg_q ^ pol_q;
      end
   end

   // ==========================================
   // register read port
   // unmapped or write-only addresses read as zero
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= 8'h00;
         case (sfr_addr)
            `PWC_ADDR_CON0: begin
               sfr_rdata[`PWC_CS_HI:`PWC_CS_LO] <= cs_q;
               sfr_rdata[`PWC_IP_HI:`PWC_IP_LO] <= ip_q;
               sfr_rdata[`PWC_POL_BIT]          <= pol_q;
               sfr_rdata[`PWC_FSTOP_BIT]        <= fstop_q;
            end
            `PWC_ADDR_CON1: begin
               sfr_rdata[`PWC_RUN_BIT]  <= run_q;
               sfr_rdata[`PWC_TGEN_BIT] <= tgen_q;
               sfr_rdata[`PWC_ESF_BIT]  <= esf_q;
               sfr_rdata[`PWC_FLG_BIT]  <= flg_q;
               sfr_rdata[`PWC_ACT_BIT]  <= act_q;
            end
            `PWC_ADDR_CON2: begin
               sfr_rdata[`PWC_MODE_HI:`PWC_MODE_LO] <= mode_q;
               sfr_rdata[`PWC_EXCL_BIT]             <= excl_q;
               sfr_rdata[`PWC_EDGE_HI:`PWC_EDGE_LO] <= edge_q;
               sfr_rdata[`PWC_OST_BIT]              <= ost_q;
            end
            default: begin
               sfr_rdata <= 8'h00;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// [verification/pwc_channel_ctrl_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module pwc_channel_ctrl_assertions #(
   parameter ADDR_W = 16
) (
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic [ADDR_W-1:0] sfr_addr,
   input wire logic              sfr_wr,
   input wire logic              sfr_rd,
   input wire logic [7:0]        sfr_rdata,
   input wire logic              low_speed_clock,
   input wire logic              high_timebase_clock,
   input wire logic              pll_clock,
   input wire logic              count_step,
   input wire logic              counter_clear,
   input wire logic              buffer_reload,
   input wire logic              pwm_out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ==========
   // helpers: count clock falls, reserved-bit masks
   wire  [2:0] cks = {pll_clock, high_timebase_clock, low_speed_clock};
   logic [2:0] cks_q;
   logic [2:0] fall_q;
   logic [7:0] mask;
   wire        fall = |(cks_q & ~cks);
   always @(posedge clk) begin
      cks_q  <= cks;
      fall_q <= {fall_q[1:0], fall};
   end
   // unmapped places read all zero
   always @* begin
      case (sfr_addr)
         16'hf914, 16'hf915: mask = 8'h00;
         16'hf916: mask = 8'hc0;
         16'hf917: mask = 8'h1c;
         16'hf918: mask = 8'h48;
         default: mask = 8'hff;
      endcase
   end
   sequence s_cnt_wr;
      sfr_wr && (sfr_addr == 16'hf914 || sfr_addr == 16'hf915);
   endsequence
   sequence s_clr_soon;
      ##[1:2] counter_clear;
   endsequence
   // ==========
   // properties
   AST_CNT_WR: assert property (s_cnt_wr |-> s_clr_soon)
      else $error("counter write gave no clear");
   AST_RSVD_RD: assert property (
      sfr_rd |=> (sfr_rdata & $past(mask)) == 8'h00)
      else $error("reserved bits read nonzero");
   AST_RELOAD_CLR: assert property (buffer_reload |-> counter_clear)
      else $error("reload without clear");
   AST_RELOAD_NOSTEP: assert property (buffer_reload |-> !count_step)
      else $error("reload with step");
   AST_STEP_NOCLR: assert property (count_step |-> !counter_clear)
      else $error("step with clear");
   AST_RELOAD_ONE: assert property (buffer_reload |=> !buffer_reload)
      else $error("reload longer than one cycle");
   AST_STEP_CLK: assert property (count_step |-> |fall_q)
      else $error("step without count clock fall");
   AST_RST_OUT: assert property ($fell(sys_rst) |-> pwm_out)
      else $error("output not idle high after reset");
endmodule
bind pwc_channel_ctrl pwc_channel_ctrl_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .low_speed_clock(low_speed_clock),
   .high_timebase_clock(high_timebase_clock), .pll_clock(pll_clock),
   .count_step(count_step), .counter_clear(counter_clear),
   .buffer_reload(buffer_reload), .pwm_out(pwm_out));
`default_nettype wire

// [verification/pwc_src.sv]
`timescale 1ns/100ps
`default_nettype none
module pwc_src (
   input  wire logic clk,
   input  wire logic trg_req,
   input  wire logic emg_req,
   output logic      ls_clk,
   output logic      htb_clk,
   output logic      pll_clk,
   output var logic  trg,
   output var logic  emg
);
   // ==========
   // count clocks run free, faster ones keep runs short
   logic [3:0] div_q = 4'h0;
   always @(posedge clk) begin
      div_q <= div_q + 4'h1;
      trg   <= trg_req;
      emg   <= emg_req;
   end
   assign ls_clk  = div_q[3];
   assign htb_clk = div_q[2];
   assign pll_clk = div_q[1];
endmodule
`default_nettype wire

// [verification/pwc_channel_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module pwc_channel_ctrl_tb;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [15:0] sfr_addr = 16'h0000;
   logic [7:0]  sfr_wdata = 8'h00;
   logic [7:0]  sfr_rdata, rd_v;
   logic        sfr_wr = 1'b0, sfr_rd = 1'b0, pm = 1'b0, dm = 1'b0;
   logic        trg_req = 1'b0, emg_req = 1'b0;
   logic        ls, htb, pll, trg, emg, step, clr, rld, irq, pwm_out;
   int          err_count = 0, num_checks = 0, cyc = 0, n_irq, n_clr, i;
   always #4 clk = ~clk;
   pwc_src u_src (.clk(clk), .trg_req(trg_req), .emg_req(emg_req),
      .ls_clk(ls), .htb_clk(htb), .pll_clk(pll), .trg(trg), .emg(emg));
   pwc_channel_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .low_speed_clock(ls), .high_timebase_clock(htb),
      .pll_clock(pll), .ext_trigger(trg), .emergency_stop(emg),
      .period_match(pm), .duty_match(dm), .count_step(step),
      .counter_clear(clr), .buffer_reload(rld), .pwm_irq(irq),
      .pwm_out(pwm_out));
   // ==========
   // tasks
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task rchk(input logic [15:0] a, input logic [7:0] e);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      rd_v = sfr_rdata;
      chk(rd_v, e);
   endtask
   // pulses sampled mid-cycle, away from the edge
   task watch(input int n);
      n_irq = 0;
      n_clr = 0;
      repeat (n) begin
         @(negedge clk);
         n_irq += irq;
         n_clr += clr;
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end
   // ==========
   // tests
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      rchk(16'hf916, 8'h00);
      rchk(16'hf917, 8'h40);
      rchk(16'hf918, 8'h00);
      rchk(16'hf919, 8'h00);
      wr(16'hf916, 8'hff);
      rchk(16'hf916, 8'h3f);
      wr(16'hf918, 8'hff);
      rchk(16'hf918, 8'hb7);
      wr(16'hf918, 8'h00);
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         wr(16'hf916, i[7:0]);
         wr(16'hf917, 8'h01);
         watch(40);
         rchk(16'hf917, (i == 3) ? 8'h41 : 8'hc1);
         wr(16'hf917, 8'h00);
         watch(40);
         rchk(16'hf917, 8'h40);
      end
      $display("test clock select done");
      for (i = 0; i < 8; i++) begin
         wr(16'hf916, {4'h0, i[2:1], 2'h2});
         wr(16'hf917, 8'h01);
         pm = ~i[0];
         dm = i[0];
         watch(20);
         pm = 1'b0;
         dm = 1'b0;
         chk(n_irq != 0, i[0] ? i[2:1] != 0 : i[2:1] != 1);
         rchk(16'hf917, i[0] ? 8'h81 : 8'hc1);
         chk(pwm_out, !i[0]);
         wr(16'hf917, 8'h00);
         watch(20);
      end
      rchk(16'hf917, 8'h00);
      wr(16'hf915, 8'ha5);
      rchk(16'hf917, 8'h40);
      $display("test interrupt point done");
      wr(16'hf918, 8'h80);
      wr(16'hf917, 8'h01);
      watch(12);
      pm = 1'b1;
      watch(12);
      pm = 1'b0;
      watch(20);
      rchk(16'hf917, 8'h40);
      wr(16'hf918, 8'h27);
      wr(16'hf917, 8'h02);
      trg_req = 1'b1;
      watch(20);
      rchk(16'hf917, 8'hc3);
      wr(16'hf918, 8'h37);
      wr(16'hf918, 8'hb7);
      trg_req = 1'b0;
      watch(20);
      chk(n_clr != 0, 8'h01);
      chk(n_irq != 0, 8'h01);
      rchk(16'hf917, 8'h42);
      wr(16'hf918, 8'hb5);
      rchk(16'hf918, 8'hb5);
      wr(16'hf917, 8'h00);
      trg_req = 1'b1;
      watch(20);
      rchk(16'hf917, 8'h40);
      trg_req = 1'b0;
      $display("test trigger done");
      wr(16'hf917, 8'h01);
      wr(16'hf916, 8'h22);
      watch(20);
      rchk(16'hf917, 8'h41);
      chk(pwm_out, 8'h01);
      wr(16'hf916, 8'h02);
      emg_req = 1'b1;
      @(negedge clk);
      emg_req = 1'b0;
      watch(10);
      rchk(16'hf917, 8'h60);
      wr(16'hf917, 8'h20);
      rchk(16'hf917, 8'h40);
      wr(16'hf916, 8'h10);
      watch(4);
      chk(pwm_out, 8'h00);
      $display("test stop and polarity done");
      conclude();
   end
endmodule
`default_nettype wire
